// [pcg_clock_gen.sv]
// Clock generator with PLL ratio control, lock status and power-save modes
// Summary of operation
// - Mode pin is caught at reset and held: low means PLL, high means direct.
// - Direct mode: system clock is the oscillator input halved.
// - PLL mode after reset: system clock is five times the input.
// - PLL mode with input lost: clock free-runs near 1 MHz.
// - Ratio register takes a write only after the protect key.
// - Ratio 00 gives x5, 10 gives x1, 11 gives half; 01 is refused.
// - PLL counts as unlocked after reset and after leaving STOP until lock time passes.
// - Status register shows the lock flag.
// - Status register shows a protect error flag set by a bad protected write.
// - Oscillator settle time is shorter than lock time; lock governs readiness.
// - HALT stops only the CPU clock.
// - IDLE stops every internal clock, oscillator and PLL keep running.
// - Leaving IDLE resumes at once, no settle wait.
// - IDLE is entered by a protected write to power-save control.
// - STOP is entered by a protected write and halts oscillator, PLL, all clocks.
// - After STOP the system clock waits for the oscillator settle time.
// - Clock output inhibit keeps the system clock off its output pin.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "pcg_consts.svh"

module pcg_clock_gen #(
  parameter int CNT_W = 16,
  parameter int OSC_STAB_CYC = (`PCG_OSC_STAB_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS,
  parameter int LOCK_CYC = (`PCG_LOCK_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS,
  parameter int LOSS_CYC = 1000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic mode_select_pin_i,
  input wire logic osc_input_pin_i,
  output logic system_clock_output_pin_o,
  // Core events
  input wire logic halt_req_i,
  input wire logic wake_i,
  // Clock gates
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_run_o,
  output logic pll_run_o,
  output logic sys_clk_o,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output pcg_pkg::pcg_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output pcg_pkg::pcg_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pcg_pkg::*;

  localparam int FREE_HALF = `PCG_CLK_KHZ / (2 * `PCG_FREE_RUN_KHZ);

  // Half period of the generated clock in reference cycles
  function automatic logic [CNT_W-1:0] half_period(input logic [CNT_W-1:0] per, input logic [1:0] ratio,
                                                   input logic lost);
    logic [CNT_W-1:0] h;
    h = CNT_W'(FREE_HALF);
    if (!lost) begin
      case (ratio)
        PCG_RATIO_X1: h = per >> 1;
        PCG_RATIO_HALF: h = per;
        default: h = per / CNT_W'(2 * `PCG_PLL_MULT);
      endcase
    end
    if (h == '0) begin
      h = CNT_W'(1);
    end
    return h;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic direct_q;
  logic [1:0] ratio_q, ratio_d;
  logic [1:0] clko_q, clko_d;
  logic arm_q, arm_d;
  logic perr_q, perr_d;
  pcg_state_e st_q, st_d;
  logic [CNT_W-1:0] wait_q, wait_d;
  logic [CNT_W-1:0] lock_q, lock_d;
  logic osc_q, osc_d;
  logic [CNT_W-1:0] gap_q, gap_d, per_q, per_d, tick_q, tick_d;
  logic lost_q, lost_d, clk_q, clk_d, clko_pin_q, clko_pin_d;
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [3:0] awa_q, awa_d;
  logic [7:0] wd_q, wd_d;
  logic wen_q, wen_d;
  logic [31:0] rd_q, rd_d;
  pcg_resp_t br_q, br_d, rr_q, rr_d;
  logic do_wr, go_stop, go_idle, locked;

  // ----------------------------------------------------------------
  // Mode pin capture
  // ----------------------------------------------------------------
  // Caught every cycle that reset is held, frozen after release
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      direct_q <= mode_select_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are latched separately; the write acts once both are held
  assign do_wr = awr_q == 1'b0 && wr_q == 1'b0 && !bv_q;
  always_comb begin
    awr_d = awr_q;
    wr_d = wr_q;
    awa_d = awa_q;
    wd_d = wd_q;
    wen_d = wen_q;
    bv_d = bv_q;
    br_d = br_q;
    arr_d = arr_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_awvalid && awr_q) begin
      awa_d = s_axi_awaddr;
      awr_d = 1'b0;
    end
    if (s_axi_wvalid && wr_q) begin
      wd_d = s_axi_wdata[7:0];
      wen_d = s_axi_wstrb[0];
      wr_d = 1'b0;
    end
    if (do_wr) begin
      bv_d = 1'b1;
      br_d = (awa_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
      awr_d = 1'b1;
      wr_d = 1'b1;
    end
    if (s_axi_arvalid && arr_q) begin
      arr_d = 1'b0;
      rv_d = 1'b1;
      rr_d = 2'h0;
      case (s_axi_araddr)
        `PCG_OFF_RATIO: rd_d = {30'h0, ratio_q};
        `PCG_OFF_STATUS: rd_d = {27'h0, perr_q, 3'h0, locked};
        `PCG_OFF_PSAVE: rd_d = {24'h0, clko_q, 6'h0};
        `PCG_OFF_PROT: rd_d = 32'h0;
        default: begin
          rd_d = 32'h0;
          rr_d = 2'h2;
        end
      endcase
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
      arr_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      awa_q <= 4'h0;
      wd_q <= 8'h0;
      wen_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= 2'h0;
    end else begin
      awr_q <= awr_d;
      wr_q <= wr_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      wen_q <= wen_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  // ----------------------------------------------------------------
  // Protected registers
  // ----------------------------------------------------------------
  // Key write arms one following write; any other write with byte 0 strobed disarms
  always_comb begin
    ratio_d = ratio_q;
    clko_d = clko_q;
    arm_d = arm_q;
    perr_d = perr_q;
    go_stop = 1'b0;
    go_idle = 1'b0;
    if (do_wr && wen_q) begin
      arm_d = 1'b0;
      case (awa_q)
        `PCG_OFF_PROT: arm_d = (wd_q == `PCG_PROT_KEY);
        `PCG_OFF_STATUS: begin
          if (wd_q[`PCG_PERR_BIT]) begin
            perr_d = 1'b0;
          end
        end
        `PCG_OFF_RATIO: begin
          if (!arm_q) begin
            perr_d = 1'b1;
          end else if (wd_q[1:0] != PCG_RATIO_BAD) begin
            ratio_d = wd_q[`PCG_RATIO_HIGH_BIT:`PCG_RATIO_LOW_BIT];
          end
        end
        `PCG_OFF_PSAVE: begin
          if (!arm_q) begin
            perr_d = 1'b1;
          end else begin
            clko_d = wd_q[`PCG_PS_CLKO_HI:`PCG_PS_CLKO_LO];
            go_stop = wd_q[`PCG_PS_STOP_BIT];
            go_idle = wd_q[`PCG_PS_IDLE_BIT];
          end
        end
        default: arm_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ratio_q <= `PCG_RATIO_RST;
      clko_q <= `PCG_CLKO_RST;
      arm_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      clko_q <= clko_d;
      arm_q <= arm_d;
      perr_q <= perr_d;
    end
  end

  // ----------------------------------------------------------------
  // Power-save sequencer and lock timer
  // ----------------------------------------------------------------
  // Lock timer runs from reset and restarts on leaving STOP; it is longer than the
  // oscillator wait, so lock is the last thing to become ready
  assign locked = lock_q == CNT_W'(LOCK_CYC);
  always_comb begin
    st_d = st_q;
    wait_d = wait_q;
    lock_d = lock_q;
    if (st_q != PCG_ST_STOP && !locked) begin
      lock_d = lock_q + CNT_W'(1);
    end
    case (st_q)
      PCG_ST_NORMAL: begin
        if (go_stop) begin
          st_d = PCG_ST_STOP;
        end else if (go_idle) begin
          st_d = PCG_ST_IDLE;
        end else if (halt_req_i) begin
          st_d = PCG_ST_HALT;
        end
      end
      PCG_ST_HALT, PCG_ST_IDLE: begin
        if (wake_i) begin
          st_d = PCG_ST_NORMAL;
        end
      end
      PCG_ST_STOP: begin
        lock_d = '0;
        if (wake_i) begin
          st_d = PCG_ST_OSC_WAIT;
          wait_d = '0;
        end
      end
      PCG_ST_OSC_WAIT: begin
        wait_d = wait_q + CNT_W'(1);
        if (wait_q == CNT_W'(OSC_STAB_CYC - 1)) begin
          st_d = PCG_ST_NORMAL;
        end
      end
      default: st_d = PCG_ST_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= PCG_ST_NORMAL;
      wait_q <= '0;
      lock_q <= '0;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock synthesis
  // ----------------------------------------------------------------
  // The input period is measured in reference cycles; the output toggles at a
  // fraction of it. Resolution is limited by the 50 MHz reference.
  always_comb begin
    osc_d = osc_input_pin_i;
    gap_d = gap_q;
    per_d = per_q;
    lost_d = lost_q;
    tick_d = tick_q;
    clk_d = clk_q;
    if (osc_input_pin_i && !osc_q) begin
      per_d = gap_q + CNT_W'(1);
      gap_d = '0;
      lost_d = 1'b0;
    end else if (gap_q == CNT_W'(LOSS_CYC)) begin
      lost_d = 1'b1;
    end else begin
      gap_d = gap_q + CNT_W'(1);
    end
    if (direct_q) begin
      if (osc_input_pin_i && !osc_q) begin
        clk_d = !clk_q;
      end
    end else if (tick_q + CNT_W'(1) >= half_period(per_q, ratio_q, lost_q)) begin
      tick_d = '0;
      clk_d = !clk_q;
    end else begin
      tick_d = tick_q + CNT_W'(1);
    end
    // IDLE, STOP and the oscillator wait hold the system clock low
    if (st_q != PCG_ST_NORMAL && st_q != PCG_ST_HALT) begin
      clk_d = 1'b0;
    end
    clko_pin_d = clk_d && clko_d != `PCG_CLKO_INHIBIT;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      osc_q <= 1'b0;
      gap_q <= '0;
      per_q <= '0;
      lost_q <= 1'b0;
      tick_q <= '0;
      clk_q <= 1'b0;
      clko_pin_q <= 1'b0;
    end else begin
      osc_q <= osc_d;
      gap_q <= gap_d;
      per_q <= per_d;
      lost_q <= lost_d;
      tick_q <= tick_d;
      clk_q <= clk_d;
      clko_pin_q <= clko_pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Gates are registered from the next state, so each comes from a flop and changes with st_q
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_run_o <= 1'b0;
      pll_run_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= st_d == PCG_ST_NORMAL;
      periph_clk_en_o <= st_d == PCG_ST_NORMAL || st_d == PCG_ST_HALT;
      osc_run_o <= !direct_q && st_d != PCG_ST_STOP;
      pll_run_o <= !direct_q && st_d != PCG_ST_STOP;
    end
  end

  assign sys_clk_o = clk_q;
  assign system_clock_output_pin_o = clko_pin_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_mode_held: assert property ($stable(direct_q)) else $error("mode latch changed");
  a_ratio_guard: assert property (!arm_q && do_wr && wen_q && awa_q == `PCG_OFF_RATIO |=>
    $stable(ratio_q) && perr_q) else $error("unarmed ratio write took effect");
  a_ratio_legal: assert property (ratio_q != PCG_RATIO_BAD) else $error("prohibited ratio held");
  a_lock_restart: assert property (st_q == PCG_ST_STOP |=> !locked) else $error("lock kept through stop");
  a_lock_order: assert property (st_q == PCG_ST_NORMAL && $past(st_q) == PCG_ST_OSC_WAIT |-> !locked)
    else $error("lock came before oscillator wait ended");
  a_halt_gates: assert property (st_q == PCG_ST_HALT |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("halt gating wrong");
  a_idle_gates: assert property (st_q == PCG_ST_IDLE |-> !periph_clk_en_o && osc_run_o == !direct_q)
    else $error("idle gating wrong");
  a_idle_wake: assert property (st_q == PCG_ST_IDLE && wake_i |=> st_q == PCG_ST_NORMAL && cpu_clk_en_o)
    else $error("idle release delayed");
  a_stop_all: assert property (st_q == PCG_ST_STOP |-> (!osc_run_o && !pll_run_o) ##1 !sys_clk_o)
    else $error("stop left clocks running");
  a_stop_wait: assert property ($rose(st_q == PCG_ST_OSC_WAIT) |-> !sys_clk_o [*8])
    else $error("clock ran during oscillator wait");
  a_clko_off: assert property (clko_q == `PCG_CLKO_INHIBIT && $past(clko_q) == `PCG_CLKO_INHIBIT |->
    !system_clock_output_pin_o) else $error("inhibited clock output toggled");

  c_stop_cycle: cover property (st_q == PCG_ST_STOP ##[1:50] st_q == PCG_ST_OSC_WAIT);
  c_idle_cycle: cover property (st_q == PCG_ST_IDLE ##1 st_q == PCG_ST_NORMAL);
  c_ratio_set: cover property (arm_q && do_wr && awa_q == `PCG_OFF_RATIO);
  c_perr_set: cover property ($rose(perr_q));
endmodule

// [pcg_consts.svh]
// Offsets, field positions, reset values and timing figures of the clock generator
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG_OFF_RATIO 4'h0
`define PCG_OFF_STATUS 4'h4
`define PCG_OFF_PSAVE 4'h8
`define PCG_OFF_PROT 4'hc

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define PCG_RATIO_LOW_BIT 0
`define PCG_RATIO_HIGH_BIT 1
`define PCG_LOCK_BIT 0
`define PCG_PERR_BIT 4
`define PCG_PS_STOP_BIT 1
`define PCG_PS_IDLE_BIT 2
`define PCG_PS_CLKO_LO 6
`define PCG_PS_CLKO_HI 7
`define PCG_RATIO_RST 2'h0
`define PCG_CLKO_RST 2'h0
`define PCG_CLKO_INHIBIT 2'h3
`define PCG_PROT_KEY 8'ha5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCG_CLK_KHZ 50000
`define PCG_CLK_NS 20
`define PCG_OSC_STAB_NS 20000
`define PCG_LOCK_NS 40000
`define PCG_FREE_RUN_KHZ 1000
`define PCG_PLL_MULT 5

`endif

// [pcg_pkg.sv]
// Types shared by the clock generator
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_RATIO_X5,
    PCG_RATIO_BAD,
    PCG_RATIO_X1,
    PCG_RATIO_HALF
  } pcg_ratio_e;

  typedef enum logic [2:0] {
    PCG_ST_NORMAL,
    PCG_ST_HALT,
    PCG_ST_IDLE,
    PCG_ST_STOP,
    PCG_ST_OSC_WAIT
  } pcg_state_e;

  typedef logic [1:0] pcg_resp_t;
endpackage

// [pcg_osc_model.sv]
// Behavioural oscillator source that feeds the clock generator input pin
`timescale 1ns/10ps

module pcg_osc_model #(
  parameter int HALF_CYC = 50
) (
  // Clock
  input wire logic ref_clk_i,
  // Control
  input wire logic run_i,
  // Pin
  output logic osc_input_pin_o
);
  int cnt_q;

  // A dead source stands still low, so input loss is really seen as loss
  always_ff @(posedge ref_clk_i) begin
    if (!run_i) begin
      cnt_q <= 0;
      osc_input_pin_o <= 1'b0;
    end else if (cnt_q == HALF_CYC - 1) begin
      cnt_q <= 0;
      osc_input_pin_o <= ~osc_input_pin_o;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// [pll_clock_gen_power_save_tb_top.sv]
// Self-checking bench for the clock generator: bus, ratios, lock and power-save modes
`timescale 1ns/10ps
`include "pcg_consts.svh"

module pll_clock_gen_power_save_tb_top;
  import pcg_pkg::*;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int OSC_STAB = 10;
  localparam int LOCK = 40;
  // Loss limit must exceed the input period, or every period would read as a lost input
  localparam int LOSS = 150;
  localparam int IN_HALF = 50;
  localparam int WIN = 1000;
  logic ref_clk_i, rst_i, mode_select_pin_i, osc_input_pin_i, halt_req_i, wake_i, osc_on;
  logic clk_pin, cpu_en, periph_en, osc_run, pll_run, sys_clk;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  pcg_resp_t s_axi_bresp, s_axi_rresp;
  int errors = 0;
  int checks_done = 0;
  int m_ratio;
  int ratio_q[$] = '{2, 3, 1, 0};
  logic [31:0] seed = 32'd27109;

  pcg_osc_model #(.HALF_CYC(IN_HALF)) osc (.ref_clk_i(ref_clk_i), .run_i(osc_on),
    .osc_input_pin_o(osc_input_pin_i));

  pcg_clock_gen #(.OSC_STAB_CYC(OSC_STAB), .LOCK_CYC(LOCK), .LOSS_CYC(LOSS)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mode_select_pin_i(mode_select_pin_i),
    .osc_input_pin_i(osc_input_pin_i), .system_clock_output_pin_o(clk_pin),
    .halt_req_i(halt_req_i), .wake_i(wake_i), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(periph_en),
    .osc_run_o(osc_run), .pll_run_o(pll_run), .sys_clk_o(sys_clk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // Free-running 50 MHz reference
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers and behavioural model
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected system clock half period in reference cycles
  function automatic int exp_half(int ratio, bit direct, bit lost);
    if (lost) return 25;
    if (direct) return 2 * IN_HALF;
    if (ratio == 0) return 2 * IN_HALF / 10;
    if (ratio == 2) return IN_HALF;
    return 2 * IN_HALF;
  endfunction

  task automatic test_done();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Counts are edge-phase dependent, so one toggle of slack either way
  task automatic chk_near(input string what, input int exp, input int got);
    checks_done++;
    if (got < exp - 1 || got > exp + 1) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic mode);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    mode_select_pin_i <= mode;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    m_ratio = `PCG_RATIO_RST;
  endtask

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output pcg_resp_t r);
    bit aw_ok, w_ok;
    logic [31:0] rnd;
    aw_ok = 0;
    w_ok = 0;
    rnd = xs();
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_wstrb <= {rnd[11:9], 1'b1};
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk_i);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output pcg_resp_t r);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Key first, then the guarded write
  task automatic pwr(input logic [3:0] a, input logic [7:0] d);
    pcg_resp_t r;
    axi_wr(`PCG_OFF_PROT, `PCG_PROT_KEY, r);
    chk("key bresp", 0, r);
    axi_wr(a, d, r);
    chk("guarded bresp", 0, r);
  endtask

  task automatic pulse(input bit halt);
    @(posedge ref_clk_i);
    if (halt) halt_req_i <= 1'b1;
    else wake_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_req_i <= 1'b0;
    wake_i <= 1'b0;
  endtask

  task automatic cnt_tog(input int n, output int t, output int tp);
    logic ls, lp;
    t = 0;
    tp = 0;
    ls = sys_clk;
    lp = clk_pin;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (sys_clk !== ls) t++;
      if (clk_pin !== lp) tp++;
      ls = sys_clk;
      lp = clk_pin;
    end
  endtask

  task automatic wait_lock();
    logic [31:0] d;
    pcg_resp_t r;
    int n;
    n = 0;
    do begin
      axi_rd(`PCG_OFF_STATUS, d, r);
      n++;
    end while (d[`PCG_LOCK_BIT] !== 1'b1 && n < LOCK);
    chk("lock flag", 1, d[`PCG_LOCK_BIT]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    pcg_resp_t r;
    logic [31:0] d;
    int t, tp, n;
    {mode_select_pin_i, halt_req_i, wake_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    rst_i = 1'b1;
    osc_on = 1'b1;
    do_reset(1'b0);
    axi_rd(`PCG_OFF_STATUS, d, r);
    chk("lock after reset", 0, d[`PCG_LOCK_BIT]);
    wait_lock();
    axi_rd(`PCG_OFF_RATIO, d, r);
    chk("ratio reset", `PCG_RATIO_RST, d[1:0]);
    chk("ratio upper", 0, d[31:8]);
    // Every ratio code, the prohibited one in the middle
    foreach (ratio_q[i]) begin
      pwr(`PCG_OFF_RATIO, 8'(ratio_q[i]));
      if (ratio_q[i] != 1) m_ratio = ratio_q[i];
      axi_rd(`PCG_OFF_RATIO, d, r);
      chk("ratio", m_ratio, d[1:0]);
      repeat (200) @(posedge ref_clk_i);
      cnt_tog(WIN, t, tp);
      chk_near("sys toggles", WIN / exp_half(m_ratio, 0, 0), t);
      chk_near("pin toggles", WIN / exp_half(m_ratio, 0, 0), tp);
    end
    // Unguarded write is dropped and flagged
    axi_wr(`PCG_OFF_RATIO, 8'h02, r);
    axi_rd(`PCG_OFF_STATUS, d, r);
    chk("perr set", 1, d[`PCG_PERR_BIT]);
    axi_rd(`PCG_OFF_RATIO, d, r);
    chk("ratio kept", m_ratio, d[1:0]);
    axi_wr(`PCG_OFF_STATUS, 8'h10, r);
    axi_rd(`PCG_OFF_STATUS, d, r);
    chk("perr clear", 0, d[`PCG_PERR_BIT]);
    axi_rd(4'h2, d, r);
    chk("unmapped rresp", 2'b10, r);
    chk("unmapped rdata", 0, d);
    axi_wr(4'h2, 8'hff, r);
    chk("unmapped bresp", 2'b10, r);
    pwr(`PCG_OFF_PSAVE, 8'hc0);
    cnt_tog(200, t, tp);
    chk("pin inhibited", 0, tp);
    chk("pin level", 0, clk_pin);
    chk_near("sys runs", 200 / exp_half(m_ratio, 0, 0), t);
    pwr(`PCG_OFF_PSAVE, 8'h00);
    pulse(1'b1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("halt gates", 4'b0111, {cpu_en, periph_en, osc_run, pll_run});
    pulse(1'b0);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("halt release", 4'b1111, {cpu_en, periph_en, osc_run, pll_run});
    pwr(`PCG_OFF_PSAVE, 8'h04);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("idle gates", 4'b0011, {cpu_en, periph_en, osc_run, pll_run});
    pulse(1'b0);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("idle release", 4'b1111, {cpu_en, periph_en, osc_run, pll_run});
    pwr(`PCG_OFF_PSAVE, 8'h02);
    osc_on <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("stop gates", 4'b0000, {cpu_en, periph_en, osc_run, pll_run});
    pulse(1'b0);
    osc_on <= 1'b1;
    n = 0;
    while (cpu_en !== 1'b1 && n < 100) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk("stop settle wait", 1, n >= OSC_STAB && n <= OSC_STAB + 3);
    axi_rd(`PCG_OFF_STATUS, d, r);
    chk("unlocked after stop", 0, d[`PCG_LOCK_BIT]);
    wait_lock();
    // Input loss falls back to free running
    osc_on <= 1'b0;
    repeat (LOSS + 100) @(posedge ref_clk_i);
    cnt_tog(WIN, t, tp);
    chk_near("free run toggles", WIN / exp_half(0, 0, 1), t);
    osc_on <= 1'b1;
    // Direct mode: ratio register left alone here
    do_reset(1'b1);
    repeat (200) @(posedge ref_clk_i);
    #1;
    chk("direct osc pll", 2'b00, {osc_run, pll_run});
    cnt_tog(WIN, t, tp);
    chk_near("direct toggles", WIN / exp_half(0, 1, 0), t);
    test_done();
  end

  // Hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    errors++;
    test_done();
  end
endmodule
